//--- mlx_pkg.sv
// Constants, types and decode helpers for the move/load instruction executor
package mlx_pkg;
  // ==========================================
  // Opcode match values (compared against upper instruction bits)
  localparam logic [9:0] PTR_LOAD_W1 = 10'h3B8;  // [15:6]
  localparam logic [7:0] PTR_LOAD_W2 = 8'hF0;    // [15:8]
  localparam logic [5:0] MOVE_REG_OP = 6'h14;    // [15:10]
  localparam logic [5:0] OR_WREG_OP = 6'h04;     // [15:10]
  localparam logic [3:0] R2R_W1 = 4'hC;          // [15:12]
  localparam logic [3:0] SECOND_W = 4'hF;        // [15:12]
  localparam logic [7:0] BANK_LOAD_OP = 8'h01;   // [15:8]
  localparam logic [7:0] WLIT_LOAD_OP = 8'h0E;   // [15:8]
  localparam logic [6:0] STORE_W_OP = 7'h37;     // [15:9]
  // ==========================================
  // Field positions and data-space layout
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam logic [1:0] PTR_SEL_MAX = 2'h2;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [11:0] WREG_ADDR = 12'hFE8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    MLX_Q1 = 2'b00, MLX_Q2 = 2'b01, MLX_Q3 = 2'b10, MLX_Q4 = 2'b11
  } mlx_phase_t;
  typedef enum logic [2:0] {
    MLX_NOP = 3'b000, MLX_PTRLD = 3'b001, MLX_MOVREG = 3'b010, MLX_R2R = 3'b011,
    MLX_BANKLD = 3'b100, MLX_WLIT = 3'b101, MLX_STOREW = 3'b110, MLX_ORW = 3'b111
  } mlx_op_t;
  typedef struct packed {
    logic en;
    logic [11:0] addr;
    logic [7:0] data;
  } mlx_wr_t;
  // ==========================================
  // First-word opcode decode
  function automatic mlx_op_t mlx_decode(input logic [15:0] ins);
    mlx_op_t op;
    op = MLX_NOP;
    if (ins[15:6] == PTR_LOAD_W1) op = MLX_PTRLD;
    else if (ins[15:10] == MOVE_REG_OP) op = MLX_MOVREG;
    else if (ins[15:10] == OR_WREG_OP) op = MLX_ORW;
    else if (ins[15:12] == R2R_W1) op = MLX_R2R;
    else if (ins[15:8] == BANK_LOAD_OP) op = MLX_BANKLD;
    else if (ins[15:8] == WLIT_LOAD_OP) op = MLX_WLIT;
    else if (ins[15:9] == STORE_W_OP) op = MLX_STOREW;
    return op;
  endfunction
  // Banked 8-bit file field to 12-bit data address
  function automatic logic [11:0] mlx_bank_addr(input logic acc, input logic [7:0] f,
                                                input logic [7:0] bank_select_register);
    logic [3:0] bank;
    bank = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
    if (acc) bank = bank_select_register[3:0];
    return {bank, f};
  endfunction
endpackage

//--- mlx_exec.sv
// Four-phase executor for move, load and store instructions
//
// Contract
// - Pointer load puts a 12-bit literal in pointer 0..2 chosen by selector.
// - Pointer load is two words: 1110111000 ff kkkk, then 11110000 kkkkkkkk.
// - Pointer load: cycle one writes high part, cycle two low byte; flags kept.
// - Move register copies byte to W when d=0, back to register when d=1.
// - An 8-bit file field addresses anywhere in the selected 256-byte bank.
// - Access bit 0 uses the access bank; 1 uses the bank select register.
// - Register-to-register move copies any 12-bit source to any 12-bit destination.
// - It is two words: 1100 plus source, then 1111 plus destination.
// - It takes two cycles: read source, then write destination with no read.
// - W may be the source or the destination of that move.
// - Bank select load writes an 8-bit literal to the bank register; flags kept.
// - The full literal lands in the bank register in the last phase.
// - Store W writes W to the addressed register in one cycle; flags kept.
`timescale 1ns/100ps
module mlx_exec #(
  parameter int PTR_COUNT = 3
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_rd_data,
  output mlx_pkg::mlx_phase_t o_phase,
  output logic o_second,
  output logic o_rd_en,
  output logic [11:0] o_rd_addr,
  output mlx_pkg::mlx_wr_t o_wr,
  output logic [7:0] o_w,
  output logic [7:0] o_bsr,
  output logic [PTR_COUNT-1:0][11:0] o_ptr,
  output logic o_flag_n,
  output logic o_flag_z
);
  // ==========================================
  // State
  mlx_pkg::mlx_op_t op;
  logic [15:0] ir;
  logic [15:0] ir2;
  logic [7:0] opnd;
  logic [7:0] hold;

  // ==========================================
  // Decode of the word being fetched and of the latched instruction
  wire mlx_pkg::mlx_op_t fetch_op = mlx_pkg::mlx_decode(i_instr);
  wire fetch_reads = (fetch_op == mlx_pkg::MLX_MOVREG) || (fetch_op == mlx_pkg::MLX_ORW) ||
                     (fetch_op == mlx_pkg::MLX_STOREW) || (fetch_op == mlx_pkg::MLX_R2R);
  // Source of the register-to-register move is a full 12-bit address
  wire [11:0] fetch_addr = (fetch_op == mlx_pkg::MLX_R2R) ? i_instr[11:0] :
    mlx_pkg::mlx_bank_addr(i_instr[mlx_pkg::ACC_BIT], i_instr[7:0], o_bsr);
  // A second word that does not carry the expected prefix turns the cycle into a no-op
  wire word2_ok = (op == mlx_pkg::MLX_PTRLD) ? (i_instr[15:8] == mlx_pkg::PTR_LOAD_W2) :
                  (i_instr[15:12] == mlx_pkg::SECOND_W);
  wire dbit = ir[mlx_pkg::DEST_BIT];
  wire [1:0] psel = ir[5:4];
  wire psel_ok = psel <= mlx_pkg::PTR_SEL_MAX;

  // ==========================================
  // Result of the current instruction
  wire [7:0] res_data = (op == mlx_pkg::MLX_ORW) ? (opnd | o_w) :
                        (op == mlx_pkg::MLX_STOREW) ? o_w :
                        (op == mlx_pkg::MLX_R2R) ? hold :
                        (op == mlx_pkg::MLX_WLIT) ? ir[7:0] : opnd;
  wire res_mem = (((op == mlx_pkg::MLX_MOVREG) || (op == mlx_pkg::MLX_ORW)) && dbit) ||
                 (op == mlx_pkg::MLX_STOREW) || ((op == mlx_pkg::MLX_R2R) && o_second);
  wire [11:0] res_addr = (op == mlx_pkg::MLX_R2R) ? ir2[11:0] :
                         mlx_pkg::mlx_bank_addr(ir[mlx_pkg::ACC_BIT], ir[7:0], o_bsr);
  // W lives here, so a write that lands on its address is kept internal
  wire wr_is_w = res_mem && (res_addr == mlx_pkg::WREG_ADDR);
  wire w_load = wr_is_w || (op == mlx_pkg::MLX_WLIT) ||
                (((op == mlx_pkg::MLX_MOVREG) || (op == mlx_pkg::MLX_ORW)) && !dbit);
  wire flag_upd = (op == mlx_pkg::MLX_MOVREG) || (op == mlx_pkg::MLX_ORW);
  wire two_word = (op == mlx_pkg::MLX_PTRLD) || (op == mlx_pkg::MLX_R2R);
  wire mlx_pkg::mlx_wr_t next_wr = '{en: res_mem && !wr_is_w, addr: res_addr, data: res_data};

  // ==========================================
  // Phase sequencer: one instruction cycle is four clocks
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_phase <= mlx_pkg::MLX_Q1;
    end else begin
      case (o_phase)
        mlx_pkg::MLX_Q1: o_phase <= mlx_pkg::MLX_Q2;
        mlx_pkg::MLX_Q2: o_phase <= mlx_pkg::MLX_Q3;
        mlx_pkg::MLX_Q3: o_phase <= mlx_pkg::MLX_Q4;
        default: o_phase <= mlx_pkg::MLX_Q1;
      endcase
    end
  end

  // Q1 decode latches the word; read strobe stands during Q2
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      op <= mlx_pkg::MLX_NOP;
      ir <= 16'h0000;
      ir2 <= 16'h0000;
      o_rd_en <= 1'b0;
      o_rd_addr <= 12'h000;
    end else if (o_phase == mlx_pkg::MLX_Q1) begin
      if (o_second) begin
        ir2 <= i_instr;
        if (!word2_ok) op <= mlx_pkg::MLX_NOP;
        o_rd_en <= 1'b0;
      end else begin
        ir <= i_instr;
        op <= fetch_op;
        o_rd_en <= fetch_reads;
        o_rd_addr <= fetch_addr;
      end
    end else begin
      o_rd_en <= 1'b0;
    end
  end

  // Q2 read: W is served from the local copy
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      opnd <= 8'h00;
    end else if (o_rd_en) begin
      opnd <= (o_rd_addr == mlx_pkg::WREG_ADDR) ? o_w : i_rd_data;
    end
  end

  // Q3 process: external write strobe stands for the whole of Q4
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wr <= '0;
    end else if (o_phase == mlx_pkg::MLX_Q3) begin
      o_wr <= next_wr;
    end else begin
      o_wr.en <= 1'b0;
    end
  end

  // Q4 write of internal registers and word sequencing
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_w <= 8'h00;
      o_bsr <= 8'h00;
      o_ptr <= '0;
      o_flag_n <= 1'b0;
      o_flag_z <= 1'b0;
      o_second <= 1'b0;
      hold <= 8'h00;
    end else if (o_phase == mlx_pkg::MLX_Q4) begin
      o_second <= !o_second && two_word;
      if (w_load) o_w <= res_data;
      if (op == mlx_pkg::MLX_BANKLD) o_bsr <= ir[7:0];
      if (op == mlx_pkg::MLX_R2R && !o_second) hold <= opnd;
      if (op == mlx_pkg::MLX_PTRLD && psel_ok) begin
        if (!o_second) o_ptr[psel][11:8] <= ir[3:0];
        else o_ptr[psel][7:0] <= ir2[7:0];
      end
      // Only the move register instruction, in either direction, and the OR touch flags
      if (flag_upd) begin
        o_flag_n <= res_data[7];
        o_flag_z <= res_data == mlx_pkg::BYTE_ZERO;
      end
    end
  end

  // ==========================================
  // Checks
  property p_wr_in_q4;
    @(posedge i_core_clk) disable iff (!i_resetn)
    o_wr.en |-> o_phase == mlx_pkg::MLX_Q4;
  endproperty
  a_wr_in_q4: assert property (p_wr_in_q4) else $error("write strobe outside Q4");

  property p_bank_load;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_BANKLD) |=>
      (o_bsr == $past(ir[7:0])) && $stable(o_flag_z) && $stable(o_flag_n);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank register load wrong");

  property p_wlit;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_WLIT) |=> o_w == $past(ir[7:0]) && $stable(o_flag_z);
  endproperty
  a_wlit: assert property (p_wlit) else $error("literal not loaded into W");

  property p_ptr_hi;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_PTRLD && !o_second && psel_ok) |=>
      o_second ##4 (o_ptr[$past(psel, 5)][11:8] == $past(ir[3:0], 5));
  endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high part wrong");

  property p_r2r_read;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q1 && !o_second && fetch_op == mlx_pkg::MLX_R2R) |=>
      o_rd_en && o_rd_addr == $past(i_instr[11:0]);
  endproperty
  a_r2r_read: assert property (p_r2r_read) else $error("source read missing");

  property p_no_read_w2;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q1 && o_second) |=> !o_rd_en [*4];
  endproperty
  a_no_read_w2: assert property (p_no_read_w2) else $error("read during second word");

  property p_access;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q1 && !o_second && fetch_op == mlx_pkg::MLX_MOVREG) |=>
      o_rd_addr == ($past(i_instr[mlx_pkg::ACC_BIT]) ? {$past(o_bsr[3:0]), $past(i_instr[7:0])} :
      ($past(i_instr[7]) ? {mlx_pkg::ACCESS_HI_BANK, $past(i_instr[7:0])} :
      {mlx_pkg::ACCESS_LO_BANK, $past(i_instr[7:0])}));
  endproperty
  a_access: assert property (p_access) else $error("bank selection wrong");

  property p_storew;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q3 && op == mlx_pkg::MLX_STOREW && !wr_is_w) |=>
      o_wr.en && o_wr.data == o_w && o_wr.addr == $past(res_addr);
  endproperty
  a_storew: assert property (p_storew) else $error("store of W wrong");

  property p_orw;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_ORW && !dbit) |=>
      o_w == ($past(opnd) | $past(o_w)) && o_flag_z == (o_w == mlx_pkg::BYTE_ZERO);
  endproperty
  a_orw: assert property (p_orw) else $error("OR result wrong");

  property p_movreg_w;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_MOVREG && !dbit) |=> o_w == $past(opnd);
  endproperty
  a_movreg_w: assert property (p_movreg_w) else $error("move to W wrong");

  property p_ptr_lo;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_PTRLD && o_second && psel_ok) |=>
      o_ptr[$past(psel)][7:0] == $past(ir2[7:0]);
  endproperty
  a_ptr_lo: assert property (p_ptr_lo) else $error("pointer low byte wrong");

  // Selector 3 names no pointer, so neither word may disturb any of them
  property p_ptr_refused;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_PTRLD && !psel_ok) |=> $stable(o_ptr);
  endproperty
  a_ptr_refused: assert property (p_ptr_refused) else $error("refused selector wrote a pointer");

  property p_r2r_first;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q3 && op == mlx_pkg::MLX_R2R && !o_second) |=> !o_wr.en;
  endproperty
  a_r2r_first: assert property (p_r2r_first) else $error("write in first move cycle");

  // The byte read in the first cycle must be the byte written in the second
  property p_r2r_write;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q3 && op == mlx_pkg::MLX_R2R && o_second && !wr_is_w) |=>
      o_wr.en && o_wr.addr == $past(ir2[11:0]) && o_wr.data == $past(opnd);
  endproperty
  a_r2r_write: assert property (p_r2r_write) else $error("destination write wrong");

  property p_movreg_mem;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q3 && op == mlx_pkg::MLX_MOVREG && dbit && !wr_is_w) |=>
      o_wr.en && o_wr.addr == o_rd_addr && o_wr.data == $past(opnd);
  endproperty
  a_movreg_mem: assert property (p_movreg_mem) else $error("move back to register wrong");

  property p_flags_kept;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && op != mlx_pkg::MLX_MOVREG && op != mlx_pkg::MLX_ORW) |=>
      $stable(o_flag_n) && $stable(o_flag_z);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed by a flag-free op");

  property p_w_kept;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4 && (op == mlx_pkg::MLX_STOREW || op == mlx_pkg::MLX_BANKLD)) |=>
      $stable(o_w);
  endproperty
  a_w_kept: assert property (p_w_kept) else $error("W changed by store or bank load");

  // W is internal, so a write aimed at its address must never reach the bus
  property p_w_internal;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q3 && wr_is_w) |=> !o_wr.en;
  endproperty
  a_w_internal: assert property (p_w_internal) else $error("write to W reached the bus");

  property p_rd_in_q2;
    @(posedge i_core_clk) disable iff (!i_resetn)
    o_rd_en |-> o_phase == mlx_pkg::MLX_Q2;
  endproperty
  a_rd_in_q2: assert property (p_rd_in_q2) else $error("read strobe outside Q2");

  property p_phase_wrap;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (o_phase == mlx_pkg::MLX_Q4) |=> (o_phase == mlx_pkg::MLX_Q1) ##1 (o_phase == mlx_pkg::MLX_Q2);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase order broken");

  // ==========================================
  // Coverage of the main scenarios
  c_ptr_load: cover property (@(posedge i_core_clk)
    o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_PTRLD && o_second);
  c_r2r_done: cover property (@(posedge i_core_clk) o_wr.en && op == mlx_pkg::MLX_R2R);
  c_w_as_dest: cover property (@(posedge i_core_clk) o_phase == mlx_pkg::MLX_Q4 && wr_is_w);
  c_sel_refused: cover property (@(posedge i_core_clk)
    o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_PTRLD && !psel_ok);
  c_orw_to_w: cover property (@(posedge i_core_clk)
    o_phase == mlx_pkg::MLX_Q4 && op == mlx_pkg::MLX_ORW && !dbit);
endmodule

//--- move_load_instr_exec_tb.sv
// Self-checking testbench for the move/load instruction executor
`timescale 1ns/100ps
module move_load_instr_exec_tb;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_rd_data;
  mlx_pkg::mlx_phase_t o_phase;
  logic o_second, o_rd_en, o_flag_n, o_flag_z;
  logic [11:0] o_rd_addr;
  mlx_pkg::mlx_wr_t o_wr;
  logic [7:0] o_w, o_bsr;
  logic [2:0][11:0] o_ptr;
  logic [7:0] mem [0:4095];
  mlx_pkg::mlx_wr_t exp_q[$];
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] w, b, k, v;
  logic [11:0] s, d, p;
  logic [2:0][11:0] pt;
  // ==========================================
  // Device, clock and data memory
  mlx_exec dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_instr(i_instr), .i_rd_data(i_rd_data),
    .o_phase(o_phase), .o_second(o_second), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr), .o_wr(o_wr),
    .o_w(o_w), .o_bsr(o_bsr), .o_ptr(o_ptr), .o_flag_n(o_flag_n), .o_flag_z(o_flag_z));
  initial forever #4 i_core_clk = ~i_core_clk;
  // Outside a read the bus shows inverted data, so a late sample cannot pass
  assign i_rd_data = o_rd_en ? mem[o_rd_addr] : ~mem[o_rd_addr];
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Word goes out on the edge that starts Q1, so it is stable through Q1
  task automatic issue(input logic [15:0] wd);
    @(posedge i_core_clk);
    while (o_phase !== mlx_pkg::MLX_Q4) @(posedge i_core_clk);
    i_instr <= wd;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    exp_q.push_back(mlx_pkg::mlx_wr_t'({1'b1, a, x}));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Write monitor and timeout; memory takes every strobed write
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end else if (o_wr.en === 1'b1) begin
      chk(o_phase, mlx_pkg::MLX_Q4);
      if (exp_q.size() == 0) chk(o_wr, 64'hFFFFFFFFFFFFFFFF);
      else chk(o_wr, exp_q.pop_front());
      mem[o_wr.addr] = o_wr.data;
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h5C0B));
    for (int i = 0; i < 4096; i++) mem[i] = 8'($urandom);
    pt = '0;
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    k = 8'($urandom);
    issue({8'h0E, k});
    w = k;
    b = (8'($urandom) & 8'hF0) | 8'h03;
    issue({8'h01, b});
    issue(16'h0000);
    chk(o_w, w);
    chk(o_bsr, b);
    chk({o_flag_n, o_flag_z}, 2'b00);
    $display("literal and bank loads done");
    // Banked, low access and high access addressing
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 8'($urandom) : ((i == 1) ? 8'h7F : 8'h80);
      wr((i == 0) ? {b[3:0], k} : ((i == 1) ? {4'h0, k} : {4'hF, k}), w);
      issue({7'h37, i == 0, k});
    end
    $display("store working register done");
    k = 8'($urandom);
    s = {b[3:0], k};
    wr(s, mem[s]);
    issue({6'h14, 1'b1, 1'b1, k});
    issue({6'h14, 1'b0, 1'b1, k});
    // The move to W has just begun and reads in its second clock, after the write-back landed
    mem[s] = 8'h80;
    issue(16'h0000);
    chk({o_w, o_flag_n, o_flag_z}, {8'h80, 2'b10});
    mem[s] = 8'h00;
    issue({6'h14, 1'b0, 1'b1, k});
    issue(16'h0000);
    chk({o_w, o_flag_n, o_flag_z}, {8'h00, 2'b01});
    $display("move register done");
    k = 8'($urandom);
    issue({8'h0E, k});
    w = k;
    wr(12'h020, w | mem[12'h020]);
    issue({6'h04, 1'b1, 1'b0, 8'h20});
    w = w | mem[12'h021];
    issue({6'h04, 1'b0, 1'b0, 8'h21});
    issue(16'h0000);
    chk({o_w, o_flag_n, o_flag_z}, {w, w[7], w == 8'h00});
    v = w;
    $display("or with register done");
    // Plain move, working register as source, then as destination
    for (int i = 0; i < 3; i++) begin
      // Sources and destinations sit in disjoint pages, clear of the counter, stack and interrupt page
      s = (i == 1) ? 12'hFE8 : (12'($urandom) & 12'h3FF) | 12'h800;
      d = (i == 2) ? 12'hFE8 : 12'($urandom) & 12'h3FF;
      if (i == 2) w = mem[s];
      else wr(d, (i == 1) ? w : mem[s]);
      issue({4'hC, s});
      issue({4'hF, d});
      chk(o_second, 1'b1);
    end
    issue(16'h0000);
    chk({o_w, o_second}, {w, 1'b0});
    $display("register to register move done");
    for (int sel = 0; sel < 4; sel++) begin
      p = (sel == 1) ? 12'hFFF : 12'($urandom);
      issue({10'h3B8, 2'(sel), p[11:8]});
      issue({8'hF0, p[7:0]});
      if (sel < 3) chk(o_ptr[sel][11:8], p[11:8]);
      issue(16'h0000);
      if (sel < 3) pt[sel] = p;
      chk(o_ptr, pt);
    end
    chk({o_w, o_flag_n, o_flag_z}, {w, v[7], v == 8'h00});
    $display("pointer load done");
    repeat (8) @(posedge i_core_clk);
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule
